// >>> hdl/rvo_pkg.sv
// Package for the ROM-variant option register bank: offsets, field positions, reset values.
// Assumes a 32-bit APB with one register per aligned word.
package rvo_pkg;
	localparam logic [11:0] OFF_RESET_STATUS = 12'h000;
	localparam logic [11:0] OFF_OPTION_FIRST = 12'h004;
	localparam logic [11:0] OFF_OPTION_SECOND = 12'h008;
	localparam logic [11:0] OFF_MON_CTRL = 12'h00C;
	localparam logic [11:0] OFF_MON_STATUS = 12'h010;
	localparam logic [11:0] OFF_FLASH_CTRL = 12'h020;
	localparam logic [11:0] OFF_FLASH_TEST = 12'h024;
	localparam logic [11:0] OFF_FLASH_PROT = 12'h028;
	localparam logic [11:0] OFF_ROM_WINDOW = 12'h030;
	localparam int FORCED_ENTRY_BIT = 2;
	localparam int PUMP_DISABLE_BIT = 2;
	localparam int MON_CMD_PROG = 0;
	localparam int MON_CMD_RUN_RAM = 1;
	localparam int MON_CMD_RUN_ROM = 2;
	localparam int MON_CMD_UNLOCK = 3;
	localparam int ST_SECURE = 0;
	localparam int ST_RUN_RAM = 1;
	localparam int ST_RUN_ROM = 2;
	localparam int ST_PROG_IGNORED = 3;
	localparam int ST_OPT_LOCKED = 4;
	localparam logic [7:0] RESET_STATUS_RESET = 8'h80;
	localparam logic [7:0] OPTION_WR_DEFAULT = 8'h00;
	localparam logic [7:0] MON_STATUS_RESET = 8'h01;
	localparam int ROM_DEPTH = 16;
	localparam int ROM_AW = 4;
	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
	} rvo_options_s;
endpackage

// >>> hdl/rvo_regs.sv
// Option, reset-status and debug-loader control register bank for the ROM or flash variant.
// Assumes an APB master on pclk; mask option values are parameters and reset causes come from same-clock logic.
`timescale 1ns/100ps
// Notes on behaviour
// R01 - ROM forced debug entry flag always reads zero.
// R02 - Flash control, test, protect registers absent.
// R03 - Loader programming commands never alter ROM.
// R04 - Loader runs RAM/ROM code, enforces read protection.
// R05 - Mask reset vector nonzero, points at code.
// R06 - No forced loader entry from erased vector.
// R07 - Security check protects user ROM likewise.
// R08 - Both option forms select identical options.
// R09 - ROM option bits fixed, ignore writes.
// R10 - Flash option register writable once per reset.
// R11 - ROM pump disable bit reads zero, inert.
// R12 - Removed flash addresses ignore writes.
module rvo_regs
#(
	parameter bit ROM_VARIANT = 1'b1,
	parameter logic [7:0] MASK_FIRST = 8'h00,
	parameter logic [7:0] MASK_SECOND = 8'h00
)
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reset causes and loader entry
	input wire logic [7:0] reset_cause,
	input wire logic erased_vector,
	input wire logic normal_entry,
	input wire logic security_match,
	// Options to the rest of the chip
	output rvo_pkg::rvo_options_s options,
	output logic pump_disable,
	output logic loader_active
);
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [7:0] opt1_reg;
	logic [7:0] opt1_next;
	logic [7:0] opt2_reg;
	logic [7:0] opt2_next;
	logic written_reg;
	logic written_next;
	logic [7:0] mon_reg;
	logic [7:0] mon_next;
	logic [rvo_pkg::ROM_AW-1:0] rom_addr_reg;
	logic [rvo_pkg::ROM_AW-1:0] rom_addr_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic captured_reg;
	logic captured_next;
	logic [7:0] rom_data;
	logic wr;
	logic rd;
	logic known;
	logic [7:0] opt1_eff;
	logic [7:0] opt2_eff;

	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_comb
	begin
		known = 1'b1;
		unique case (paddr)
			rvo_pkg::OFF_RESET_STATUS, rvo_pkg::OFF_OPTION_FIRST, rvo_pkg::OFF_OPTION_SECOND,
			rvo_pkg::OFF_MON_CTRL, rvo_pkg::OFF_MON_STATUS, rvo_pkg::OFF_ROM_WINDOW:
				known = 1'b1;
			default:
				known = 1'b0; // R12
		endcase
	end

	// Both forms feed the same option wiring; the source differs and the ROM form also forces the pump disable bit to zero.
	always_comb
	begin
		opt1_eff = ROM_VARIANT ? MASK_FIRST : opt1_reg; // R08 R09
		opt2_eff = ROM_VARIANT ? MASK_SECOND : opt2_reg; // R08 R09
		if (ROM_VARIANT)
			opt2_eff[rvo_pkg::PUMP_DISABLE_BIT] = 1'b0; // R11
	end

	assign options.first = opt1_eff;
	assign options.second = opt2_eff;
	assign pump_disable = opt2_eff[rvo_pkg::PUMP_DISABLE_BIT];

	always_comb
	begin
		status_next = status_reg;
		captured_next = 1'b1;
		if (!captured_reg)
			status_next = reset_cause;
		if (ROM_VARIANT)
			status_next[rvo_pkg::FORCED_ENTRY_BIT] = 1'b0; // R01
		opt1_next = opt1_reg;
		opt2_next = opt2_reg;
		written_next = written_reg;
		// A write to either option word uses the single shot for both.
		if (wr && !ROM_VARIANT && !written_reg // R10
			&& (paddr == rvo_pkg::OFF_OPTION_FIRST || paddr == rvo_pkg::OFF_OPTION_SECOND))
		begin
			if (paddr == rvo_pkg::OFF_OPTION_FIRST)
				opt1_next = pwdata[7:0];
			else
				opt2_next = pwdata[7:0];
			written_next = 1'b1;
		end
		if (ROM_VARIANT)
			written_next = 1'b1; // R09
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_reg <= rvo_pkg::RESET_STATUS_RESET;
			captured_reg <= 1'b0;
			opt1_reg <= rvo_pkg::OPTION_WR_DEFAULT;
			opt2_reg <= rvo_pkg::OPTION_WR_DEFAULT;
			written_reg <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			captured_reg <= captured_next;
			opt1_reg <= opt1_next;
			opt2_reg <= opt2_next;
			written_reg <= written_next;
		end
	end

	// Loader state: bit ST_SECURE set means ROM reads are blocked.
	always_comb
	begin
		mon_next = mon_reg;
		rom_addr_next = rom_addr_reg;
		if (normal_entry && !(ROM_VARIANT && erased_vector && !normal_entry))
			mon_next[7] = 1'b1; // R06
		if (ROM_VARIANT && erased_vector && !normal_entry)
			mon_next[7] = mon_reg[7]; // R06
		if (wr && paddr == rvo_pkg::OFF_MON_CTRL)
		begin
			if (pwdata[rvo_pkg::MON_CMD_PROG] && ROM_VARIANT)
				mon_next[rvo_pkg::ST_PROG_IGNORED] = 1'b1; // R03
			if (pwdata[rvo_pkg::MON_CMD_RUN_RAM])
				mon_next[rvo_pkg::ST_RUN_RAM] = 1'b1; // R04
			if (pwdata[rvo_pkg::MON_CMD_RUN_ROM])
				mon_next[rvo_pkg::ST_RUN_ROM] = 1'b1; // R04
			if (pwdata[rvo_pkg::MON_CMD_UNLOCK] && security_match)
				mon_next[rvo_pkg::ST_SECURE] = 1'b0; // R07
		end
		if (wr && paddr == rvo_pkg::OFF_ROM_WINDOW)
			rom_addr_next = pwdata[rvo_pkg::ROM_AW-1:0];
		mon_next[rvo_pkg::ST_OPT_LOCKED] = written_next;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mon_reg <= rvo_pkg::MON_STATUS_RESET;
			rom_addr_reg <= '0;
		end
		else
		begin
			mon_reg <= mon_next;
			rom_addr_reg <= rom_addr_next;
		end
	end

	assign loader_active = mon_reg[7];

	rvo_rom u_rom
	(
		.pclk(pclk),
		.presetn(presetn),
		.addr(rom_addr_reg),
		.rdata(rom_data)
	);

	// Read data is latched in the setup cycle so it is stable through the access phase.
	always_comb
	begin
		prdata_next = prdata_reg;
		if (rd)
		begin
			prdata_next = 32'h0000_0000; // R02 R12
			if (known)
			begin
				unique case (paddr)
					rvo_pkg::OFF_RESET_STATUS: prdata_next[7:0] = status_reg; // R01
					rvo_pkg::OFF_OPTION_FIRST: prdata_next[7:0] = opt1_eff;
					rvo_pkg::OFF_OPTION_SECOND: prdata_next[7:0] = opt2_eff; // R11
					rvo_pkg::OFF_MON_STATUS: prdata_next[7:0] = mon_reg;
					rvo_pkg::OFF_ROM_WINDOW: prdata_next[7:0] = mon_reg[rvo_pkg::ST_SECURE] ? 8'h00 : rom_data; // R04 R07
					default: prdata_next[7:0] = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else
			prdata_reg <= prdata_next;
	end

	assign prdata = prdata_reg;

	AST_STATUS_BIT2: assert property (@(posedge pclk) disable iff (!presetn) // R01
		ROM_VARIANT |-> !status_reg[rvo_pkg::FORCED_ENTRY_BIT]) else $error("forced entry flag set");
	AST_PUMP_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R11
		ROM_VARIANT |-> !pump_disable) else $error("pump disable not zero");
	AST_ROM_FIXED: assert property (@(posedge pclk) disable iff (!presetn) // R09
		ROM_VARIANT |-> options.first == MASK_FIRST
		&& options.second == (MASK_SECOND & ~(8'h01 << rvo_pkg::PUMP_DISABLE_BIT)))
		else $error("rom options differ from mask");
	AST_ONE_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // R10
		written_reg |=> $stable(opt1_reg) && $stable(opt2_reg)) else $error("option rewritten");
	AST_FIRST_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(!ROM_VARIANT && !written_reg && wr && paddr == rvo_pkg::OFF_OPTION_FIRST)
		|=> opt1_reg == $past(pwdata[7:0]) && written_reg) else $error("first option write lost");
	AST_UNMAPPED_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R12
		(rd && paddr == rvo_pkg::OFF_FLASH_CTRL) |=> prdata == 32'h0000_0000) else $error("flash reg read nonzero");
	AST_SECURE_READ: assert property (@(posedge pclk) disable iff (!presetn) // R07
		(rd && paddr == rvo_pkg::OFF_ROM_WINDOW && mon_reg[rvo_pkg::ST_SECURE]) |=> prdata == 32'h0000_0000)
		else $error("secured rom visible");
	AST_PROG_NOTED: assert property (@(posedge pclk) disable iff (!presetn) // R03
		(ROM_VARIANT && wr && paddr == rvo_pkg::OFF_MON_CTRL && pwdata[rvo_pkg::MON_CMD_PROG])
		|=> mon_reg[rvo_pkg::ST_PROG_IGNORED]) else $error("program command not flagged");
	COV_UNLOCK: cover property (@(posedge pclk) disable iff (!presetn) $fell(mon_reg[rvo_pkg::ST_SECURE]));
	COV_OPT_WRITE: cover property (@(posedge pclk) disable iff (!presetn) $rose(written_reg));
	COV_ROM_READ: cover property (@(posedge pclk) disable iff (!presetn) rd && paddr == rvo_pkg::OFF_ROM_WINDOW);
endmodule

// >>> hdl/rvo_rom.sv
// Small mask-programmed user ROM image with a registered read port.
// Assumes the image is fixed at build time; there is no write port at all.
`timescale 1ns/100ps
module rvo_rom
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Read port
	input wire logic [rvo_pkg::ROM_AW-1:0] addr,
	output logic [7:0] rdata
);
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	// No write path exists, so programming commands cannot alter contents.
	always_comb
	begin
		rdata_next = {4'hA, addr} ^ 8'h5C;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	assign rdata = rdata_reg;
endmodule

// >>> sim/rom_variant_option_regs_bench.sv
// Self-checking bench for the option, status and loader register bank.
// Assumes zero-wait APB; both variants share one bus and have separate read data, option and pump outputs.
`timescale 1ns/100ps
module rom_variant_option_regs_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] reset_cause = 8'hFF;
	logic erased_vector = 1'b1;
	logic normal_entry = 1'b0;
	logic security_match = 1'b0;
	logic use_f = 1'b0;
	logic [31:0] prdata, prdata_f, r, rom_b;
	logic pready, pslverr, pump_disable, pump_f, loader_active;
	rvo_pkg::rvo_options_s options, options_f;
	int n_fail = 0;
	int tests_run = 0;
	int cmd[3] = '{rvo_pkg::MON_CMD_RUN_RAM, rvo_pkg::MON_CMD_RUN_ROM, rvo_pkg::MON_CMD_PROG};
	int st[3] = '{rvo_pkg::ST_RUN_RAM, rvo_pkg::ST_RUN_ROM, rvo_pkg::ST_PROG_IGNORED};
	always #5 pclk = ~pclk;
	// Mask bit 2 of the second byte is set so that its forced zero is visible.
	rvo_regs #(.ROM_VARIANT(1'b1), .MASK_FIRST(8'hA5), .MASK_SECOND(8'h5F)) rvo_regs_inst
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_cause(reset_cause),
		.erased_vector(erased_vector), .normal_entry(normal_entry), .security_match(security_match),
		.options(options), .pump_disable(pump_disable), .loader_active(loader_active)
	);
	rvo_regs #(.ROM_VARIANT(1'b0)) rvo_regs_flash_inst
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata_f), .pready(), .pslverr(), .reset_cause(reset_cause),
		.erased_vector(erased_vector), .normal_entry(normal_entry), .security_match(security_match),
		.options(options_f), .pump_disable(pump_f), .loader_active()
	);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = use_f ? prdata_f : prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (3000) @(posedge pclk);
		n_fail++;
		test_done();
	end
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, rvo_pkg::OFF_RESET_STATUS, 32'h0);
		check("forced entry flag", 32'(r[rvo_pkg::FORCED_ENTRY_BIT]), 32'h0);
		check("slave error", 32'(pslverr), 32'h0);
		for (int i = 0; i < 2; i++)
		begin
			apb(1'b0, rvo_pkg::OFF_OPTION_FIRST, 32'h0);
			check("option first", r, 32'h000000A5);
			apb(1'b0, rvo_pkg::OFF_OPTION_SECOND, 32'h0);
			check("option second", r, 32'h0000005B);
			apb(1'b1, rvo_pkg::OFF_OPTION_FIRST, 32'h0000003C);
			apb(1'b1, rvo_pkg::OFF_OPTION_SECOND, 32'h000000FF);
		end
		check("options out", 32'(options.first), 32'h000000A5);
		check("pump disable", 32'(pump_disable), 32'h0);
		check("loader idle", 32'(loader_active), 32'h0);
		// erased_vector stays high throughout, so normal entry is driven with the erased-vector flag also set.
		normal_entry <= 1'b1;
		repeat (2) @(posedge pclk);
		check("loader entry", 32'(loader_active), 32'h1);
		apb(1'b0, rvo_pkg::OFF_MON_STATUS, 32'h0);
		check("secure", 32'(r[rvo_pkg::ST_SECURE]), 32'h1);
		apb(1'b1, rvo_pkg::OFF_ROM_WINDOW, 32'h3);
		apb(1'b0, rvo_pkg::OFF_ROM_WINDOW, 32'h0);
		check("secure rom read", r, 32'h0);
		security_match <= 1'b1;
		apb(1'b1, rvo_pkg::OFF_MON_CTRL, 32'h1 << rvo_pkg::MON_CMD_UNLOCK);
		apb(1'b0, rvo_pkg::OFF_ROM_WINDOW, 32'h0);
		rom_b = r;
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, rvo_pkg::OFF_MON_CTRL, 32'h1 << cmd[i]);
			apb(1'b0, rvo_pkg::OFF_MON_STATUS, 32'h0);
			check("loader status", 32'(r[st[i]]), 32'h1);
		end
		check("unlocked", 32'(r[rvo_pkg::ST_SECURE]), 32'h0);
		apb(1'b0, rvo_pkg::OFF_ROM_WINDOW, 32'h0);
		check("rom after program", r, rom_b);
		// A fresh reset re-arms the single flash option write for the second instance.
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, rvo_pkg::OFF_FLASH_CTRL + 12'(4 * i), 32'hFFFFFFFF);
			apb(1'b0, rvo_pkg::OFF_FLASH_CTRL + 12'(4 * i), 32'h0);
			check("removed register", r, 32'h0);
		end
		use_f = 1'b1;
		apb(1'b1, rvo_pkg::OFF_OPTION_FIRST, 32'h0000003C);
		apb(1'b1, rvo_pkg::OFF_OPTION_SECOND, 32'h00000044);
		apb(1'b0, rvo_pkg::OFF_OPTION_FIRST, 32'h0);
		check("flash option first", r, 32'h0000003C);
		apb(1'b0, rvo_pkg::OFF_OPTION_SECOND, 32'h0);
		check("flash option second", r, 32'h0);
		check("flash options out", 32'(options_f.first), 32'h0000003C);
		check("flash pump", 32'(pump_f), 32'h0);
		test_done();
	end
endmodule
